// file: bench/epd_serial_monitor.sv
`timescale 1ns/1ps
module epd_serial_monitor (
   // System
   input wire logic clk,
   input wire logic rst,
   // Link
   input wire logic serialClk,
   input wire logic serialDataIn,
   input wire logic chipSelN,
   input wire logic dataCmd,
   input wire logic modeSelect
);
   // ==========================================
   // Rising serial clock edges in this frame
   logic [3:0] rises_r;
   always_ff @(posedge clk) begin
      if (rst || chipSelN) begin
         rises_r <= 4'h0;
      end else if ($rose(serialClk)) begin
         rises_r <= rises_r + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Checks
   chk_frame_bits: assert property ($rose(chipSelN) |->
      rises_r == ($past(modeSelect) ? 4'h9 : 4'h8)) else $error("bad bit count");
   chk_idle_clock: assert property (chipSelN |-> !serialClk)
      else $error("clock outside frame");
   chk_mode_hold: assert property (!chipSelN && !$past(chipSelN) |-> $stable(modeSelect))
      else $error("mode moved in frame");
   chk_dc_hold: assert property (!chipSelN && !$past(chipSelN) |-> $stable(dataCmd))
      else $error("dc moved in frame");
   chk_dc_three: assert property (!chipSelN && modeSelect |-> !dataCmd)
      else $error("dc high in 3-wire");
   chk_data_hold: assert property (serialClk && $past(serialClk) |-> $stable(serialDataIn))
      else $error("data moved while clock high");
   chk_high_phase: assert property ($rose(serialClk) |-> serialClk[*8])
      else $error("clock high too short");
   chk_cs_setup: assert property ($fell(chipSelN) |-> !serialClk[*8])
      else $error("select setup too short");
   chk_frame_end: assert property ($fell(chipSelN) |-> ##[200:300] $rose(chipSelN))
      else $error("frame length wrong");
   cover property ($rose(chipSelN) && $past(modeSelect));
   cover property ($rose(chipSelN) && !$past(modeSelect));
   cover property (!chipSelN && dataCmd);
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import epd_serial_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic useThreeWire = 1'b0;
   logic sendValid = 1'b0;
   logic sendIsData = 1'b0;
   logic [7:0] sendByte = 8'h00;
   logic sendReady, ramWrite, cmdWrite, nopSeen, ramWriteB, cmdWriteB, nopSeenB;
   logic [7:0] rxByte, rxByteB;
   logic [10:0] gotB = 11'h000;
   int err_total = 0;
   int cmp_count = 0;
   epd_serial_if link ();
   epd_serial_if linkB ();
   always #5 clk = ~clk;
   epd_serial_host u_epd_serial_host (.clk, .rst, .useThreeWire, .sendValid, .sendIsData,
      .sendByte, .sendReady, .link(link));
   epd_serial_device u_epd_serial_device (.clk, .rst, .link(link), .rxByte, .ramWrite,
      .cmdWrite, .nopSeen);
   // Second device faces a hand-driven link that breaks framing on purpose.
   epd_serial_device u_epd_serial_device_b (.clk, .rst, .link(linkB), .rxByte(rxByteB),
      .ramWrite(ramWriteB), .cmdWrite(cmdWriteB), .nopSeen(nopSeenB));
   epd_serial_monitor u_epd_serial_monitor (.clk, .rst, .serialClk(link.serialClk),
      .serialDataIn(link.serialDataIn), .chipSelN(link.chipSelN), .dataCmd(link.dataCmd),
      .modeSelect(link.modeSelect));
   always @(posedge clk) begin
      if (ramWriteB | cmdWriteB | nopSeenB) gotB <= {ramWriteB, cmdWriteB, nopSeenB, rxByteB};
   end
   task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic three, input logic isData, input logic [7:0] b,
         input logic [2:0] exp);
      int n;
      @(negedge clk);
      useThreeWire = three;
      sendIsData = isData;
      sendByte = b;
      sendValid = 1'b1;
      while (sendReady !== 1'b1) @(negedge clk);
      @(negedge clk);
      sendValid = 1'b0;
      for (n = 0; n < 400 && !(ramWrite | cmdWrite | nopSeen); n++) @(negedge clk);
      cmp({ramWrite, cmdWrite, nopSeen, rxByte}, {exp, b});
   endtask
   // Bit-bangs nb bits of v at a 160 ns serial clock, then deselects.
   task automatic bang(input logic m, input logic dc, input int nb, input logic [8:0] v);
      linkB.modeSelect = m;
      linkB.dataCmd = dc;
      linkB.chipSelN = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         linkB.serialDataIn = v[i];
         repeat (8) @(negedge clk);
         linkB.serialClk = 1'b1;
         repeat (8) @(negedge clk);
         linkB.serialClk = 1'b0;
      end
      repeat (8) @(negedge clk);
      linkB.chipSelN = 1'b1;
      linkB.serialDataIn = ~linkB.serialDataIn;
      repeat (8) @(negedge clk);
   endtask
   task automatic four_wire;
      send(1'b0, 1'b0, 8'h3c, 3'b010);
      send(1'b0, 1'b1, 8'ha5, 3'b100);
      send(1'b0, 1'b0, 8'hff, 3'b001);
      send(1'b0, 1'b1, 8'hff, 3'b100);
   endtask
   task automatic three_wire;
      send(1'b1, 1'b1, 8'h81, 3'b100);
      send(1'b1, 1'b0, 8'h7e, 3'b010);
      send(1'b1, 1'b0, 8'hff, 3'b001);
   endtask
   task automatic partial_frame;
      bang(1'b0, 1'b0, 3, 9'h1ff);
      cmp(gotB, 11'h000);
      bang(1'b0, 1'b0, 8, 9'h0a5);
      cmp(gotB, {3'b010, 8'ha5});
      bang(1'b1, 1'b1, 9, 9'h03c);
      cmp(gotB, {3'b010, 8'h3c});
   endtask
   task automatic complete_run;
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      linkB.serialClk = 1'b0;
      linkB.serialDataIn = 1'b0;
      linkB.chipSelN = 1'b1;
      linkB.dataCmd = 1'b0;
      linkB.modeSelect = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      four_wire();
      three_wire();
      four_wire();
      partial_frame();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      complete_run();
   end
endmodule

// file: logic/epd_serial_device.sv
`timescale 1ns/1ps

// How it works
// - Strap low: 4-wire, 8-bit, separate D/C line
// - Strap high: 3-wire, 9-bit frames
// - CS low, D/C selects; sample rising clock
// - MSB first into 8-bit shift register
// - Completed byte goes to RAM or command
// - Write only, never drives toward host
// - 3-wire: flag bit then bits 7..0
// - 3-wire flag 1 data, 0 command
// - 3-wire ignores the D/C pin
// - Command FF is a no-operation
module epd_serial_device
   import epd_serial_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Link
   epd_serial_if.device link,
   // Received bytes
   output logic [7:0] rxByte,
   output logic ramWrite,
   output logic cmdWrite,
   output logic nopSeen
);
   import epd_serial_pkg::*;

   // ==========================================================
   // Decoding helpers
   // The all-ones command is told apart from all others in this one place.
   function automatic logic isNopByte(input logic [7:0] value);
      return value == NOP_CMD;
   endfunction

   // Index of the last bit of a frame, counted from zero after the select falls.
   function automatic logic [3:0] frameLastBit(input logic threeWireMode);
      return threeWireMode ? LAST_BIT3 : LAST_BIT4;
   endfunction

   // A byte goes to display memory when its data/command selection is high.
   function automatic logic routeToRam(input logic threeWireMode, input logic flag,
         input logic dcPin);
      return threeWireMode ? flag : dcPin;
   endfunction

   // ==========================================================
   // Pin synchronisers
   // Every pin crosses two flops. The sampled serial clock edge therefore lags the
   // pin by two cycles, and data, select and mode are delayed by the same amount,
   // so setup and hold seen at the pins carry over to the sampled copies.
   // The select resets to its idle level, high, so no frame seems to start.
   logic [1:0] sclkS_r;
   logic [1:0] sdiS_r;
   logic [1:0] csS_r;
   logic [1:0] dcS_r;
   logic [1:0] modeS_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclkS_r <= 2'h0;
         sdiS_r <= 2'h0;
         csS_r <= 2'h3;
         dcS_r <= 2'h0;
         modeS_r <= 2'h0;
      end else begin
         sclkS_r <= {sclkS_r[0], link.serialClk};
         sdiS_r <= {sdiS_r[0], link.serialDataIn};
         csS_r <= {csS_r[0], link.chipSelN};
         dcS_r <= {dcS_r[0], link.dataCmd};
         modeS_r <= {modeS_r[0], link.modeSelect};
      end
   end

   // Sampled data levels, as seen by everything past the synchronisers.
   logic sdiBit;
   logic dcBit;

   assign sdiBit = sdiS_r[1];
   assign dcBit = dcS_r[1];

   // ==========================================================
   // Serial clock edge detection
   // The previous level resets low, the idle level of the serial clock, so no
   // false edge follows reset.
   logic sclkPrev_r;
   logic sclkRise;
   logic selected;
   logic rise;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclkPrev_r <= 1'b0;
      end else begin
         sclkPrev_r <= sclkS_r[1];
      end
   end

   assign sclkRise = sclkS_r[1] & ~sclkPrev_r;
   assign selected = ~csS_r[1];
   assign rise = sclkRise & selected;

   // ==========================================================
   // Mode selection
   // The strap is read on every cycle rather than latched per frame; the board
   // holds it still, so a strap that moves in mid-frame is not guarded against.
   logic threeWire;
   logic [3:0] lastBit;

   assign threeWire = modeS_r[1];
   assign lastBit = frameLastBit(threeWire);

   // ==========================================================
   // Frame counting
   // A high select clears the count, so a cut frame is dropped and the next
   // frame always starts at its first bit.
   logic [3:0] bitCnt_r;
   logic done;
   logic flagSlot;

   assign done = rise && (bitCnt_r == lastBit);
   assign flagSlot = threeWire && (bitCnt_r == CNT_RESET);

   always_ff @(posedge clk) begin
      if (rst || !selected) begin
         bitCnt_r <= CNT_RESET;
      end else if (done) begin
         bitCnt_r <= CNT_RESET;
      end else if (rise) begin
         bitCnt_r <= bitCnt_r + 4'h1;
      end
   end

   // ==========================================================
   // Shift register and routing flag
   logic [7:0] shift_r;
   logic flag_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (rise && flagSlot) begin
         flag_r <= sdiBit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_r <= BYTE_RESET;
      end else if (rise && !flagSlot) begin
         shift_r <= {shift_r[6:0], sdiBit};
      end
   end

   // ==========================================================
   // Byte delivery
   // The byte is handed over on the cycle of its last sampled rise, so it is
   // taken from the shift register together with the incoming bit.
   // A byte is reported three cycles after the pin edge that ends it, so a
   // host must not expect an earlier answer.
   logic [7:0] full;
   logic isData;
   logic isNop;

   assign full = {shift_r[6:0], sdiBit};
   assign isData = routeToRam(threeWire, flag_r, dcBit);
   assign isNop = isNopByte(full);

   always_ff @(posedge clk) begin
      if (rst) begin
         rxByte <= BYTE_RESET;
      end else if (done) begin
         rxByte <= full;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ramWrite <= 1'b0;
      end else begin
         ramWrite <= done && isData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmdWrite <= 1'b0;
      end else begin
         cmdWrite <= done && !isData && !isNop;
      end
   end

   // The all-ones command gets its own pulse and never reaches the command
   // register, so it cannot disturb a write sequence in progress.
   always_ff @(posedge clk) begin
      if (rst) begin
         nopSeen <= 1'b0;
      end else begin
         nopSeen <= done && !isData && isNop;
      end
   end

   // ==========================================================
   // Write-only port
   // The link modport carries inputs only, so nothing in this module can drive
   // data back toward the host, whatever mode the strap selects.
endmodule

// file: logic/epd_serial_host.sv
`timescale 1ns/1ps
module epd_serial_host
   import epd_serial_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rst,
   // Mode strap driven by this end
   input wire logic useThreeWire,
   // Request
   input wire logic sendValid,
   input wire logic sendIsData,
   input wire logic [7:0] sendByte,
   output logic sendReady,
   // Link
   epd_serial_if.host link
);
   import epd_serial_pkg::*;
   typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, LOW = 2'b11, HIGH = 2'b10} state_e;
   state_e state_r;
   logic [4:0] tick_r;
   logic [8:0] sh_r;
   logic [3:0] left_r;
   logic sclk_r, cs_r, dc_r, mode_r;
   assign sendReady = (state_r == IDLE);
   assign link.serialClk = sclk_r;
   assign link.serialDataIn = sh_r[8];
   assign link.chipSelN = cs_r;
   assign link.dataCmd = dc_r;
   assign link.modeSelect = mode_r;
   // ==========================================================
   // Frame sequencer
   // The serial clock comes from a divider of clk; each phase lasts at least half
   // the least cycle time, so the link never runs faster than allowed.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= IDLE;
         tick_r <= 5'h0;
         sh_r <= 9'h000;
         left_r <= 4'h0;
         sclk_r <= 1'b0;
         cs_r <= 1'b1;
         dc_r <= 1'b0;
         mode_r <= 1'b0;
      end else begin
         unique case (state_r)
            IDLE: begin
               sclk_r <= 1'b0;
               cs_r <= 1'b1;
               mode_r <= useThreeWire;
               if (sendValid) begin
                  if (useThreeWire) begin
                     sh_r <= {sendIsData, sendByte};
                     left_r <= LAST_BIT3;
                     dc_r <= 1'b0;
                  end else begin
                     sh_r <= {sendByte, 1'b0};
                     left_r <= LAST_BIT4;
                     dc_r <= sendIsData;
                  end
                  cs_r <= 1'b0;
                  tick_r <= CSS_CNT;
                  state_r <= SETUP;
               end
            end
            SETUP: begin
               if (tick_r == 5'h0) begin
                  tick_r <= HALF_CNT;
                  state_r <= LOW;
               end else begin
                  tick_r <= tick_r - 5'h1;
               end
            end
            LOW: begin
               if (tick_r == 5'h0) begin
                  sclk_r <= 1'b1;
                  tick_r <= HALF_CNT;
                  state_r <= HIGH;
               end else begin
                  tick_r <= tick_r - 5'h1;
               end
            end
            HIGH: begin
               if (tick_r == 5'h0) begin
                  sclk_r <= 1'b0;
                  tick_r <= HALF_CNT;
                  if (left_r == 4'h0) begin
                     // Select rises with the last falling clock, so even back-to-back
                     // frames leave it high for at least one cycle between them.
                     cs_r <= 1'b1;
                     state_r <= IDLE;
                  end else begin
                     left_r <= left_r - 4'h1;
                     sh_r <= {sh_r[7:0], 1'b0};
                     state_r <= LOW;
                  end
               end else begin
                  tick_r <= tick_r - 5'h1;
               end
            end
         endcase
      end
   end
endmodule

// file: logic/epd_serial_if.sv
`timescale 1ns/1ps
interface epd_serial_if;
   logic serialClk;
   logic serialDataIn;
   logic chipSelN;
   logic dataCmd;
   logic modeSelect;
   modport device (
      input serialClk,
      input serialDataIn,
      input chipSelN,
      input dataCmd,
      input modeSelect
   );
   modport host (
      output serialClk,
      output serialDataIn,
      output chipSelN,
      output dataCmd,
      output modeSelect
   );
endinterface

// file: logic/epd_serial_pkg.sv
package epd_serial_pkg;
   // ==========================================================
   // Frame layout
   localparam int BYTE_BITS = 8;
   localparam int FRAME3_BITS = 9;
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [3:0] LAST_BIT4 = 4'h7;
   localparam logic [3:0] LAST_BIT3 = 4'h8;
   localparam logic [7:0] NOP_CMD = 8'hff;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // ==========================================================
   // Link timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_CYCLE_NS = 250;
   localparam int SCLK_HALF_CYC = (SCLK_CYCLE_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] HALF_CNT = 5'(SCLK_HALF_CYC);
   localparam int CSS_NS = 120;
   localparam int CSS_CYC = (CSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] CSS_CNT = 5'(CSS_CYC);
endpackage
